/* File: hw/micro_branch_skip_sequencer.v */
// Function
// RULE_01 - Clear-bit micro branches on tested bit zero, set-bit micro on one
// RULE_02 - Selected nibble feeds selector; opcode bits 6 and 5 pick the bit
// RULE_03 - Taken branch flag blocks latch read at finish, loading a NO-OP
// RULE_04 - During the two-clock NO-OP the target micro is fetched
// RULE_05 - Taken branch suppresses the normal 16-position address step
// RULE_06 - Zero displacement branch still re-fetches the in-line micro
// RULE_07 - Opcode bit four set subtracts displacement, clear adds it
// RULE_08 - No branch: address steps, next micro loads at finish
// RULE_09 - Target address loads end of S1; target micro loads at NO-OP finish
// RULE_10 - Decimal source: test micros take 3 or 5 clocks, finish at S2
// RULE_11 - Skip micro takes 2/3 clocks, plus 2-clock NO-OP when skipping
// RULE_12 - Skip compares nibble to mask bits 3..0, qualified by variant
// RULE_13 - Fetch latch captures store data mid-period while fetch set S0/S1
// RULE_14 - Each skip micro finish advances address by 16 positions
// RULE_15 - Discrete source of skip micro keeps source enable through T3
// RULE_16 - Decimal skip sources X and Y; fetch cleared at end of S1
// RULE_17 - Skip flag set at period edge, blocks latch read at finish
// RULE_18 - During a skip, increments and fetches continue unchanged
// RULE_19 - Transfer micro always 32-bit store access, at most 24 bits moved
// RULE_20 - Transfer opcode bit five selects upward or downward access
// RULE_21 - Transfer micro lasts 8 clocks, optionally stepping FA and FL
// RULE_22 - At S0 address goes to write buffer, at T1 into saved register
// RULE_23 - Forced NO-OP is all zeros into the instruction register
// RULE_24 - Displacement applies at address bits 7..4, fifteen micros each way
// RULE_25 - Skip variant decode is a parameterised table
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "micro_seq_defines.vh"

module micro_branch_skip_sequencer #(
  parameter [7:0] SKIP_TABLE = `SKIP_TABLE
) (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire [15:0] store_data_in,
  input  wire [3:0]  source_nibble_in,
  output reg  [23:0] store_addr_out,
  output reg         store_read_out,
  output reg         source_enable_out,
  output reg         xy_source_out,
  output reg         xfer_active_out,
  output reg         xfer_down_out,
  output reg  [4:0]  xfer_bits_out
);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  reg  [31:0] ctrl_r;
  reg  [23:0] mar_r;
  reg  [15:0] mir_r;
  reg  [15:0] latch_r;
  reg  [23:0] lwb_r;
  reg  [23:0] saved_r;
  reg  [23:0] fa_r;
  reg  [23:0] fl_r;
  reg  [2:0]  s_cnt_r;
  reg         phase_r;
  reg         fetch_r;
  reg         branch_r;
  reg         skip_r;

  wire        run       = ctrl_r[`CTRL_RUN_BIT];
  wire [3:0]  op        = mir_r[`OP_HI:`OP_LO];
  wire [3:0]  src_sel   = mir_r[`SRC_HI:`SRC_LO];
  wire        is_br     = (op == `OP_CLR_BR) || (op == `OP_SET_BR);
  wire        is_skip   = (op == `OP_SKIP);
  wire        is_test   = is_br || is_skip;
  wire        is_xfer   = (op == `OP_XFER);
  wire        decimal   = (src_sel == `SRC_DECIMAL) &&
                          (ctrl_r[`CTRL_CPU_HI:`CTRL_CPU_LO] == `CPU_DECIMAL);
  wire        discrete  = src_sel[3] && (src_sel != `SRC_DECIMAL);
  wire        end_s     = run && phase_r;
  wire        tested    = source_nibble_in[mir_r[6:5]];             // RULE_02
  wire        br_taken  = (op == `OP_SET_BR) ? tested : !tested;    // RULE_01
  wire        mask_eq   = (source_nibble_in == mir_r[3:0]);         // RULE_12
  wire        skip_hit  = SKIP_TABLE[{mir_r[5:4], mask_eq}];        // RULE_25
  reg  [2:0]  fin_s;
  wire        finish    = end_s && (s_cnt_r == fin_s);
  wire        lrd_en    = finish && !branch_r && !skip_r;           // RULE_03
  wire [23:0] disp      = {16'h0000, mir_r[3:0], 4'h0};             // RULE_24
  wire [23:0] target    = mir_r[`DISP_SIGN] ? mar_r - disp          // RULE_07
                                            : mar_r + disp;
  wire [23:0] fa_step   = mir_r[`XFER_DEC] ? fa_r - 24'h000001
                                           : fa_r + 24'h000001;
  wire [23:0] fl_step   = mir_r[`XFER_DEC] ? fl_r - 24'h000001
                                           : fl_r + 24'h000001;

  always @* begin
    if (is_test && decimal) begin
      fin_s = `FIN_S_DEC;                                           // RULE_10
    end else if (is_xfer) begin
      fin_s = `FIN_S_XFER;                                          // RULE_21
    end else begin
      fin_s = `FIN_S_SHORT;                                         // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         aw_full_r;
  reg         w_full_r;
  wire        do_write  = aw_full_r && w_full_r && !s_axi_bvalid_out;
  wire        wr_ctrl   = do_write && (aw_addr_r == `OFS_CTRL);
  wire        wr_mar    = do_write && (aw_addr_r == `OFS_MAR);
  wire        wr_fa     = do_write && (aw_addr_r == `OFS_FA);
  wire        wr_fl     = do_write && (aw_addr_r == `OFS_FL);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] ctrl_w = merge(ctrl_r, w_data_r, w_strb_r);
  wire [31:0] mar_w  = merge({8'h00, mar_r}, w_data_r, w_strb_r);
  wire [31:0] fa_w   = merge({8'h00, fa_r}, w_data_r, w_strb_r);
  wire [31:0] fl_w   = merge({8'h00, fl_r}, w_data_r, w_strb_r);

  // ----------------------------------------------------------------
  // Period timing, flags and micro flow
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_r   <= `CTRL_RESET;
      mar_r    <= `MAR_RESET;
      mir_r    <= 16'h0000;
      latch_r  <= 16'h0000;
      lwb_r    <= 24'h000000;
      saved_r  <= 24'h000000;
      fa_r     <= 24'h000000;
      fl_r     <= 24'h000000;
      s_cnt_r  <= 3'h0;
      phase_r  <= 1'b0;
      fetch_r  <= 1'b1;
      branch_r <= 1'b0;
      skip_r   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_w;
      end
      // Software may only move the address while the sequencer is stopped
      if (wr_mar && !run) begin
        mar_r <= mar_w[23:0];
      end
      if (run) begin
        phase_r <= !phase_r;
      end
      if (end_s) begin
        s_cnt_r <= finish ? 3'h0 : s_cnt_r + 3'h1;
      end
      // Capture while fetch is set, on the mid-period edge; the last
      // capture is the one closest to T3 when the store data settles
      if (run && !phase_r && fetch_r) begin
        latch_r <= store_data_in;                                   // RULE_13
      end
      if (end_s && s_cnt_r == 3'h1) begin
        fetch_r <= 1'b0;                                            // RULE_16
      end
      if (end_s && s_cnt_r == 3'h0 && is_br && br_taken) begin
        branch_r <= 1'b1;
      end
      if (end_s && s_cnt_r == 3'h0 && is_skip && skip_hit) begin
        skip_r <= 1'b1;                                             // RULE_17
      end
      if (end_s && s_cnt_r == 3'h1 && branch_r) begin
        mar_r <= target;                                            // RULE_09
      end
      if (run && !phase_r && s_cnt_r == 3'h0 && is_xfer) begin
        lwb_r <= mar_r;                                             // RULE_22
      end
      if (end_s && s_cnt_r == 3'h0 && is_xfer) begin
        saved_r <= lwb_r;                                           // RULE_22
      end
      if (finish) begin
        // Every micro ends by starting the next fetch, even a NO-OP
        fetch_r  <= 1'b1;                                           // RULE_04
        branch_r <= 1'b0;
        skip_r   <= 1'b0;
        if (lrd_en) begin
          mir_r <= latch_r;                                         // RULE_08
        end else begin
          mir_r <= 16'h0000;                                        // RULE_23
        end
        if (!branch_r) begin
          mar_r <= mar_r + `ADDR_STEP;                       // RULE_14 RULE_18
        end
        if (is_xfer && mir_r[`XFER_FA_EN]) begin
          fa_r <= fa_step;                                          // RULE_21
        end
        if (is_xfer && mir_r[`XFER_FL_EN]) begin
          fl_r <= fl_step;                                          // RULE_21
        end
      end
      if (wr_fa && !run) begin
        fa_r <= fa_w[23:0];
      end
      if (wr_fl && !run) begin
        fl_r <= fl_w[23:0];
      end
    end
  end
  // A taken branch skips the address step at finish; RULE_05 RULE_06

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  wire src_on = run && is_test &&
                ((s_cnt_r == 3'h0) ||
                 (s_cnt_r == 3'h1 && (!phase_r ||
                                      (is_skip && discrete))));     // RULE_15

  always @(posedge clk_in) begin
    if (reset_in) begin
      store_addr_out    <= `MAR_RESET;
      store_read_out    <= 1'b0;
      source_enable_out <= 1'b0;
      xy_source_out     <= 1'b0;
      xfer_active_out   <= 1'b0;
      xfer_down_out     <= 1'b0;
      xfer_bits_out     <= 5'h00;
    end else begin
      store_addr_out    <= mar_r;
      store_read_out    <= run && fetch_r;
      source_enable_out <= src_on;
      xy_source_out     <= src_on && decimal;                       // RULE_16
      // Store access is always a full 32-bit cycle; width caps the move
      xfer_active_out   <= run && is_xfer &&
                           (s_cnt_r >= `XFER_S_START);              // RULE_19
      xfer_down_out     <= is_xfer && mir_r[`XFER_DOWN];            // RULE_20
      xfer_bits_out     <= (fl_r > {19'h00000, `XFER_MAX_BITS}) ?
                           `XFER_MAX_BITS : fl_r[4:0];              // RULE_19
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg        rd_ok;

  always @* begin
    rd_ok  = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr_in)
      `OFS_CTRL:   rd_mux = ctrl_r;
      `OFS_MAR:    rd_mux = {8'h00, mar_r};
      `OFS_MIR:    rd_mux = {16'h0000, mir_r};
      `OFS_LATCH:  rd_mux = {16'h0000, latch_r};
      `OFS_SAVED:  rd_mux = {8'h00, saved_r};
      `OFS_FA:     rd_mux = {8'h00, fa_r};
      `OFS_FL:     rd_mux = {8'h00, fl_r};
      `OFS_STATUS: rd_mux = {24'h000000, s_cnt_r, phase_r,
                             fetch_r, skip_r, branch_r, run};
      default:     rd_ok  = 1'b0;
    endcase
  end

  wire wr_known = (aw_addr_r[7:5] == 3'h0) && (aw_addr_r[1:0] == 2'h0);

  always @(posedge clk_in) begin
    if (reset_in) begin
      aw_addr_r         <= 8'h00;
      w_data_r          <= 32'h00000000;
      w_strb_r          <= 4'h0;
      aw_full_r         <= 1'b0;
      w_full_r          <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'h0;
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= 2'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr_r         <= s_axi_awaddr_in;
        aw_full_r         <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data_r         <= s_axi_wdata_in;
        w_strb_r         <= s_axi_wstrb_in;
        w_full_r         <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_known ? 2'h0 : 2'h2;
        aw_full_r        <= 1'b0;
        w_full_r         <= 1'b0;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_mux;
        s_axi_rresp_out   <= rd_ok ? 2'h0 : 2'h2;
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

endmodule

/* File: hw/micro_seq_defines.vh */
`ifndef MICRO_SEQ_DEFINES_VH
`define MICRO_SEQ_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_MAR       8'h04
`define OFS_MIR       8'h08
`define OFS_LATCH     8'h0c
`define OFS_SAVED     8'h10
`define OFS_FA        8'h14
`define OFS_FL        8'h18
`define OFS_STATUS    8'h1c

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CTRL_RUN_BIT  0
`define CTRL_CPU_LO   1
`define CTRL_CPU_HI   2
`define CPU_DECIMAL   2'h1
`define CTRL_RESET    32'h00000000
`define MAR_RESET     24'h000000

// ----------------------------------------------------------------
// Micro word fields
// ----------------------------------------------------------------
`define OP_HI         15
`define OP_LO         12
`define OP_CLR_BR     4'h4
`define OP_SET_BR     4'h5
`define OP_SKIP       4'h6
`define OP_XFER       4'h7
`define SRC_HI        11
`define SRC_LO        8
`define SRC_DECIMAL   4'hf
`define DISP_SIGN     4
`define XFER_DOWN     5
`define XFER_FA_EN    4
`define XFER_FL_EN    3
`define XFER_DEC      2

// ----------------------------------------------------------------
// Timing in S periods and address step
// ----------------------------------------------------------------
`define FIN_S_SHORT   3'h1
`define FIN_S_DEC     3'h2
`define FIN_S_XFER    3'h7
`define XFER_S_START  3'h3
`define ADDR_STEP     24'h000010
`define XFER_MAX_BITS 5'h18
`define SKIP_TABLE    8'ha6

`endif

/* File: testbench/seq_checker_asserts.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checker for the micro sequencer
// ------------------------------------------------------------
module seq_checker (
  input wire        clk_in,
  input wire        reset_in,
  input wire        s_axi_awvalid_in,
  input wire        s_axi_awready_out,
  input wire        s_axi_wvalid_in,
  input wire        s_axi_wready_out,
  input wire        s_axi_bvalid_out,
  input wire        s_axi_arvalid_in,
  input wire        s_axi_arready_out,
  input wire        s_axi_rvalid_out,
  input wire [23:0] store_addr_out,
  input wire        store_read_out,
  input wire        xfer_active_out,
  input wire [4:0]  xfer_bits_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Transfer body covers S3 to S7, ten clock cycles
  sequence xfer_body;
    xfer_active_out[*8] ##1 xfer_active_out[*2];
  endsequence
  sequence aw_w_taken;
    s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  AST_XFER_LEN: assert property (
    $rose(xfer_active_out) |-> xfer_body ##1 !xfer_active_out)
    else $error("transfer active span wrong");
  AST_XFER_BITS: assert property (
    xfer_bits_out <= 5'h18)
    else $error("transfer width above 24 bits");
  AST_ADDR_LOW: assert property (
    $changed(store_addr_out) |->
      store_addr_out[3:0] == $past(store_addr_out[3:0]))
    else $error("micro address moved below bit 4");
  AST_FETCH_GAP: assert property (
    $fell(store_read_out) |-> ##[1:13] store_read_out)
    else $error("micro fetch stopped too long");
  AST_FETCH_MIN: assert property (
    $rose(store_read_out) |-> store_read_out[*4])
    else $error("micro fetch shorter than S0 and S1");
  AST_W_ANS: assert property (
    aw_w_taken |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  AST_R_ANS: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response late");
  AST_RDY_LOW: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write ready during response");
endmodule

bind micro_branch_skip_sequencer seq_checker i_chk (
  .clk_in(clk_in), .reset_in(reset_in),
  .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .store_addr_out(store_addr_out),
  .store_read_out(store_read_out), .xfer_active_out(xfer_active_out),
  .xfer_bits_out(xfer_bits_out));

/* File: testbench/store_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// System store holding sixteen micro words
// ------------------------------------------------------------
module store_model (
  input  wire        clk_in,
  input  wire [23:0] addr_in,
  input  wire        read_in,
  output reg  [15:0] data_out
);
  reg [15:0] mem [0:15];
  reg [15:0] last_r = 16'h0000;
  // Idle store shows the inverse so a stale word cannot pass as fresh
  always @* begin
    if (read_in)
      data_out = mem[addr_in[7:4]];
    else
      data_out = ~last_r;
  end
  always @(posedge clk_in) begin
    if (read_in)
      last_r <= data_out;
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  // ------------------------------------------------------------
  // Clock, reset and drivers
  // ------------------------------------------------------------
  reg         clk_in = 1'b0;
  reg         reset_in = 1'b1;
  reg  [7:0]  awa = 8'h00;
  reg         awv = 1'b0;
  reg  [31:0] wd = 32'h00000000;
  reg         wv = 1'b0;
  reg         br = 1'b0;
  reg  [7:0]  ara = 8'h00;
  reg         arv = 1'b0;
  reg         rr = 1'b0;
  reg  [3:0]  nib = 4'h5;
  wire        awr, wr, bv, arr, rv, srd, sen, xys, xa, xd;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdat;
  wire [23:0] sad;
  wire [15:0] sdat;
  wire [4:0]  xb;
  integer     fail_count = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     nfet = 0;
  integer     last_t = 0;
  integer     k;
  reg  [23:0] la = 24'h000000;
  reg         rd_q = 1'b0;
  reg         xa_seen = 1'b0;
  // Fetch addresses and spacing in cycles, one byte per fetch
  localparam [95:0] EXP_A = 96'h00_10_30_40_50_60_70_80_90_a0_90_a0;
  localparam [95:0] EXP_G = 96'h00_04_04_04_04_04_04_04_10_06_04_04;
  always #50 clk_in = ~clk_in;

  micro_branch_skip_sequencer i_dut (
    .clk_in(clk_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .store_data_in(sdat), .source_nibble_in(nib),
    .store_addr_out(sad), .store_read_out(srd),
    .source_enable_out(sen), .xy_source_out(xys),
    .xfer_active_out(xa), .xfer_down_out(xd), .xfer_bits_out(xb));

  store_model i_store (
    .clk_in(clk_in), .addr_in(sad), .read_in(srd), .data_out(sdat));

  task automatic chk(input [31:0] e, input [31:0] g, input [63:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    reg da;
    reg dw;
    begin
      da = 1'b0;
      dw = 1'b0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (!(da && dw)) begin
        @(posedge clk_in);
        if (awr) da = 1'b1;
        if (wr) dw = 1'b1;
        if (da) awv <= 1'b0;
        if (dw) wv <= 1'b0;
      end
      while (!bv) @(posedge clk_in);
      br <= 1'b0;
      chk(32'(er), 32'(bresp), "bresp");
    end
  endtask

  task axr(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      @(posedge clk_in);
      while (!arr) @(posedge clk_in);
      arv <= 1'b0;
      while (!rv) @(posedge clk_in);
      rr <= 1'b0;
      chk(e, rdat, "rdata");
      chk(32'(er), 32'(rresp), "rresp");
    end
  endtask

  // ------------------------------------------------------------
  // Fetch trace and watchdog
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    rd_q <= srd;
    if (cyc > 2000) begin
      fail_count = fail_count + 1;
      $display("mismatch watchdog expected done seen hang");
      finish_test;
    end
    if (srd && nfet < 12 && (!rd_q || sad !== la)) begin
      chk(32'(EXP_A[95-8*nfet -: 8]), 32'(sad), "fetch");
      if (nfet > 0)
        chk(32'(EXP_G[95-8*nfet -: 8]), cyc - last_t, "gap");
      la = sad;
      last_t = cyc;
      nfet = nfet + 1;
    end
    if (xa && !xa_seen) begin
      xa_seen = 1'b1;
      chk(32'h1, 32'(xd), "down");
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    for (k = 0; k < 16; k = k + 1)
      i_store.mem[k] = 16'h0000;
    // Words that must be passed over would upset timing if run
    i_store.mem[0] = 16'h4822;
    i_store.mem[1] = 16'h7028;
    i_store.mem[2] = 16'h7028;
    i_store.mem[3] = 16'h5822;
    i_store.mem[4] = 16'h6805;
    i_store.mem[5] = 16'h7028;
    i_store.mem[6] = 16'h6804;
    i_store.mem[7] = 16'h7028;
    i_store.mem[8] = 16'h4f00;
    i_store.mem[9] = 16'h5811;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    axr(8'h00, 32'h00000000, 2'h0);
    axr(8'h04, 32'h00000000, 2'h0);
    axr(8'h08, 32'h00000000, 2'h0);
    axr(8'h20, 32'h00000000, 2'h2);
    axw(8'h20, 32'h00000001, 2'h2);
    axw(8'h14, 32'h00000100, 2'h0);
    axw(8'h18, 32'h0000001e, 2'h0);
    @(negedge clk_in);
    chk(32'h18, 32'(xb), "width");
    @(posedge clk_in);
    axw(8'h00, 32'h00000003, 2'h0);
    while (nfet < 12) @(posedge clk_in);
    axw(8'h14, 32'h00000555, 2'h0);
    axr(8'h14, 32'h00000100, 2'h0);
    axr(8'h18, 32'h0000001f, 2'h0);
    finish_test;
  end
endmodule
